// [verilog/sirq_dev.sv]
`default_nettype none
module sirq_dev (
  input  wire logic                                  clk_i,
  input  wire logic                                  rstn_i,
  sirq_link_if.dev                                   link,
  input  wire logic [sirq_pkg::SRC_CNT-1:0]          src_req_i,
  input  wire logic [sirq_pkg::SRC_CNT*sirq_pkg::CHAN_W-1:0] src_chan_i,
  input  wire logic                                  quiet_mode_wait_enable_i,
  input  wire logic                                  start_error_discard_i,
  output logic                                       quiet_mode_o,
  output logic                                       busy_o,
  output logic                                       start_error_o
);
  import sirq_pkg::*;

  sirq_dev_st_t       state_r;
  sirq_mode_t         mode_r;
  logic [1:0]         ph_r;
  logic [4:0]         frame_r;
  logic [3:0]         low_cnt_r;
  logic [2:0]         stop_cnt_r;
  logic [4:0]         wait_r;
  logic               mute_r;
  logic               err_r;
  logic               dev_o_r;
  logic               dev_oe_r;
  logic               line_mid_r;
  logic [IRQ_CNT-1:0] rep_r;
  logic [IRQ_CNT-1:0] lvl_all;
  logic [IRQ_CNT-1:0] lvl;
  logic [CHAN_W-1:0]  chan;
  logic               pclk_rise;
  logic               pclk_fall;
  logic               line_q;
  logic               start_ok;
  logic               changed;
  logic               go_qstart;
  logic               last_frame;
  logic               next_active;
  logic               stop_done;

  // pci clock is only sampled; its edges pace everything below except the line sync, which runs on every clk_i
  sirq_sync #(
    .RST_VAL (1'b0)
  ) u_pclk_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (link.pci_clk),
    .q_o    (),
    .rise_o (pclk_rise),
    .fall_o (pclk_fall)
  );

  // line idles high through the pull-up
  sirq_sync #(
    .RST_VAL (1'b1)
  ) u_line_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (link.line),
    .q_o    (line_q),
    .rise_o (),
    .fall_o ()
  );

  // take the line mid-period, so the host edge and its data never race
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_mid_r <= 1'b1;
    end else if (pclk_fall) begin
      line_mid_r <= line_q;
    end
  end

  // merge sources into per-channel levels
  always_comb begin
    lvl_all = '0;
    chan    = CHAN_NONE;
    for (int s = 0; s < SRC_CNT; s++) begin
      chan = src_chan_i[s*CHAN_W +: CHAN_W];
      if (src_req_i[s] && (chan != CHAN_NONE)) begin
        lvl_all[chan] = 1'b1;
      end
    end
  end

  // unsupported channels never reach the line
  assign lvl = lvl_all & IRQ_SUPPORTED;

  assign changed     = (lvl != rep_r);
  assign start_ok    = (low_cnt_r >= START_LOW_MIN) && (low_cnt_r <= START_LOW_MAX);
  assign last_frame  = (frame_r == FRAME_LAST);
  assign stop_done   = (state_r == DV_STOP) && line_mid_r && (stop_cnt_r != '0);
  // the frame about to open is frame_r+1, carrying level frame_r
  assign next_active = (frame_r < FRAME_IRQ_END) ? lvl[frame_r[3:0]] : 1'b0;

  // quiet start only in quiet mode, idle high line, fresh change, no wait
  assign go_qstart = (state_r == DV_IDLE) && line_mid_r && (mode_r == SIRQ_QUIET)
                     && changed && (wait_r == '0);

  // cycle sequencing, one step per pci rising edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r   <= DV_IDLE;
      ph_r      <= PH_TURN;
      frame_r   <= '0;
      low_cnt_r <= '0;
      mute_r    <= 1'b0;
    end else if (pclk_rise) begin
      case (state_r)
        DV_IDLE: begin
          if (!line_mid_r) begin
            state_r   <= DV_START;
            low_cnt_r <= 4'h1;
          end else if (go_qstart) begin
            state_r <= DV_QSTART;
          end
        end
        DV_QSTART: begin
          // our own low period counts as the first start clock
          state_r   <= DV_START;
          low_cnt_r <= 4'h1;
        end
        DV_START: begin
          if (!line_mid_r) begin
            if (low_cnt_r != LOW_CNT_SAT) begin
              low_cnt_r <= low_cnt_r + 4'h1;
            end
          end else begin
            // rising end of the start pulse is clock 0
            state_r <= DV_FRAMES;
            ph_r    <= PH_TURN;
            frame_r <= '0;
            // a bad start keeps counting but silences us unless start_error_discard_i is set
            mute_r  <= !start_ok && !start_error_discard_i;
          end
        end
        DV_FRAMES: begin
          case (ph_r)
            PH_TURN: begin
              if (last_frame) begin
                state_r <= DV_STOP;
              end else begin
                ph_r    <= PH_SAMPLE;
                frame_r <= frame_r + 5'h01;
              end
            end
            PH_SAMPLE: begin
              ph_r <= PH_REC;
            end
            default: begin
              ph_r <= PH_TURN;
            end
          endcase
        end
        DV_STOP: begin
          if (stop_done) begin
            state_r <= DV_IDLE;
          end
        end
        default: begin
          state_r <= DV_IDLE;
        end
      endcase
    end
  end

  // stop width: low periods seen after the last frame
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_cnt_r <= '0;
    end else if (pclk_rise) begin
      if (state_r != DV_STOP) begin
        stop_cnt_r <= '0;
      end else if (!line_mid_r && (stop_cnt_r != STOP_CNT_SAT)) begin
        stop_cnt_r <= stop_cnt_r + 3'h1;
      end
    end
  end

  // mode for the next cycle, plus optional quiet wait
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= SIRQ_CONT;
      wait_r <= '0;
    end else if (pclk_rise) begin
      if (stop_done) begin
        // odd widths fall back to continuous, the safe choice
        mode_r <= (stop_cnt_r == STOP_LOW_QUIET) ? SIRQ_QUIET : SIRQ_CONT;
        wait_r <= (quiet_mode_wait_enable_i && (stop_cnt_r == STOP_LOW_QUIET))
                  ? QM_WAIT_CLKS : '0;
      end else if (wait_r != '0) begin
        wait_r <= wait_r - 5'h01;
      end
    end
  end

  // pin drive: low, brief high, or released
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_o_r  <= 1'b1;
      dev_oe_r <= 1'b0;
    end else if (pclk_rise) begin
      dev_o_r  <= 1'b1;
      dev_oe_r <= 1'b0;
      if (go_qstart) begin
        dev_o_r  <= 1'b0;
        dev_oe_r <= 1'b1;
      end else if ((state_r == DV_FRAMES) && !mute_r) begin
        if ((ph_r == PH_TURN) && !last_frame && next_active) begin
          dev_o_r  <= 1'b0;
          dev_oe_r <= 1'b1;
        end else if ((ph_r == PH_SAMPLE) && dev_oe_r) begin
          dev_o_r  <= 1'b1;
          dev_oe_r <= 1'b1;
        end
      end
    end
  end

  // remember what each frame last reported, for quiet change detect
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rep_r <= '0;
    end else if (pclk_rise && (state_r == DV_FRAMES) && !mute_r && (ph_r == PH_TURN)
                 && (frame_r < FRAME_IRQ_END)) begin
      rep_r[frame_r[3:0]] <= lvl[frame_r[3:0]];
    end
  end

  // one-cycle flag for a start outside 4 to 8 lows
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_r <= 1'b0;
    end else begin
      err_r <= pclk_rise && (state_r == DV_START) && line_mid_r && !start_ok;
    end
  end

  assign link.dev_o   = dev_o_r;
  assign link.dev_oe  = dev_oe_r;
  assign quiet_mode_o = (mode_r == SIRQ_QUIET);
  assign busy_o       = (state_r != DV_IDLE);
  assign start_error_o = err_r;
endmodule
`default_nettype wire

// [verilog/sirq_pkg.sv]
`default_nettype none
package sirq_pkg;
  // system clock and link clock
  localparam int SYS_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [3:0] DIV_LAST = 4'(LINK_HALF_CYC - 1);

  // frame layout
  localparam logic [4:0] FRAME_LAST    = 5'h15;
  localparam int         FRAME_CNT     = 21;
  localparam logic [4:0] FRAME_IRQ_END = 5'h10;
  localparam int         IRQ_CNT       = 16;
  localparam logic [15:0] IRQ_SUPPORTED = 16'h0EB8;

  // phase of a link clock inside an irq/data frame
  localparam logic [1:0] PH_REC    = 2'h0;
  localparam logic [1:0] PH_TURN   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;

  // start and stop widths in link clocks
  localparam logic [3:0] START_LOW_MIN  = 4'h4;
  localparam logic [3:0] START_LOW_MAX  = 4'h8;
  localparam logic [3:0] LOW_CNT_SAT    = 4'hF;
  localparam logic [2:0] STOP_LOW_QUIET = 3'h2;
  localparam logic [2:0] STOP_LOW_CONT  = 3'h3;
  localparam logic [2:0] STOP_CNT_SAT   = 3'h7;
  localparam logic [4:0] QM_WAIT_CLKS   = 5'h10;

  // interrupt sources of the device end
  localparam int         SRC_CNT   = 4;
  localparam int         CHAN_W    = 4;
  localparam logic [3:0] CHAN_NONE = 4'h0;

  typedef enum logic {SIRQ_CONT, SIRQ_QUIET} sirq_mode_t;
  typedef enum logic [2:0] {DV_IDLE, DV_QSTART, DV_START, DV_FRAMES, DV_STOP} sirq_dev_st_t;
  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_HIGH, HS_FRAMES, HS_STOP, HS_STOPHI
  } sirq_host_st_t;
endpackage
`default_nettype wire

// [verilog/sirq_link_if.sv]
`default_nettype none
interface sirq_link_if;
  logic pci_clk;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;
  logic line;

  // open-drain wire with pull-up: any low driver wins
  assign line = ~((dev_oe & ~dev_o) | (host_oe & ~host_o));

  modport dev  (input pci_clk, input line, output dev_o, output dev_oe);
  modport host (output pci_clk, output host_o, output host_oe, input line);
endinterface
`default_nettype wire

// [verilog/sirq_sync.sv]
`default_nettype none
module sirq_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  logic q_r;
  logic agree;

  // three stages; only the second reads the first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
    end else begin
      ff1_r <= d_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // accept a change once stages two and three agree
  assign agree = (ff2_r == ff3_r);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= RST_VAL;
    end else if (agree) begin
      q_r <= ff3_r;
    end
  end

  assign q_o    = q_r;
  assign rise_o = agree & ff3_r & ~q_r;
  assign fall_o = agree & ~ff3_r & q_r;
endmodule
`default_nettype wire

// [verilog/sirq_host.sv]
`default_nettype none
module sirq_host (
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  sirq_link_if.host                           link,
  input  wire logic                           cycle_req_i,
  input  wire logic [3:0]                     start_len_i,
  input  wire logic                           stop_quiet_i,
  output logic [sirq_pkg::FRAME_CNT-1:0]      frame_lvl_o,
  output logic                                cycle_done_o,
  output logic                                quiet_mode_o,
  output logic                                busy_o
);
  import sirq_pkg::*;

  sirq_host_st_t        state_r;
  sirq_mode_t           mode_r;
  logic [3:0]           div_r;
  logic                 pclk_r;
  logic [3:0]           cnt_r;
  logic [1:0]           ph_r;
  logic [4:0]           frame_r;
  logic                 pend_r;
  logic                 stop_q_r;
  logic                 done_r;
  logic                 host_o_r;
  logic                 host_oe_r;
  logic                 smp_prev_r;
  logic [4:0]           smp_n_r;
  logic [FRAME_CNT-1:0] lvl_r;
  logic                 tick;
  logic                 rise;
  logic                 fall;
  logic                 line_q;
  logic                 take_q;
  logic [3:0]           len;
  logic [4:0]           smp_idx;

  // we make the link clock, so its edges are known here directly
  assign tick = (div_r == DIV_LAST);
  assign rise = tick & ~pclk_r;
  assign fall = tick & pclk_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r  <= '0;
      pclk_r <= 1'b0;
    end else begin
      div_r  <= tick ? 4'h0 : div_r + 4'h1;
      pclk_r <= tick ? ~pclk_r : pclk_r;
    end
  end

  sirq_sync #(
    .RST_VAL (1'b1)
  ) u_line_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (link.line),
    .q_o    (line_q),
    .rise_o (),
    .fall_o ()
  );

  // start width clamped into 4 to 8
  assign len = (start_len_i < START_LOW_MIN) ? START_LOW_MIN :
               (start_len_i > START_LOW_MAX) ? START_LOW_MAX : start_len_i;

  // device quiet start is seen mid next period, so we take over there
  assign take_q = fall && (state_r == HS_IDLE) && (mode_r == SIRQ_QUIET) && !line_q;

  // request wins over its own clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_r <= 1'b0;
    end else if (cycle_req_i) begin
      pend_r <= 1'b1;
    end else if (rise && (state_r == HS_IDLE)) begin
      pend_r <= 1'b0;
    end
  end

  // cycle sequencing; cnt_r holds the periods left in start or stop, the last of them driven high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r  <= HS_IDLE;
      cnt_r    <= '0;
      ph_r     <= PH_TURN;
      frame_r  <= '0;
      stop_q_r <= 1'b0;
    end else if (take_q) begin
      state_r <= HS_START;
      cnt_r   <= len - 4'h1;
    end else if (rise) begin
      case (state_r)
        HS_IDLE: begin
          if (pend_r) begin
            state_r <= HS_START;
            cnt_r   <= len;
          end
        end
        HS_START: begin
          if (cnt_r == 4'h1) begin
            state_r <= HS_HIGH;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        HS_HIGH: begin
          state_r <= HS_FRAMES;
          ph_r    <= PH_TURN;
          frame_r <= '0;
        end
        HS_FRAMES: begin
          case (ph_r)
            PH_TURN: begin
              if (frame_r == FRAME_LAST) begin
                state_r  <= HS_STOP;
                cnt_r    <= {1'b0, stop_quiet_i ? STOP_LOW_QUIET : STOP_LOW_CONT};
                stop_q_r <= stop_quiet_i;
              end else begin
                ph_r    <= PH_SAMPLE;
                frame_r <= frame_r + 5'h01;
              end
            end
            PH_SAMPLE: begin
              ph_r <= PH_REC;
            end
            default: begin
              ph_r <= PH_TURN;
            end
          endcase
        end
        HS_STOP: begin
          if (cnt_r == 4'h1) begin
            state_r <= HS_STOPHI;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  // pin drive follows the step just taken
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_o_r  <= 1'b1;
      host_oe_r <= 1'b0;
    end else if (take_q) begin
      host_o_r  <= 1'b0;
      host_oe_r <= 1'b1;
    end else if (rise) begin
      host_o_r  <= 1'b1;
      host_oe_r <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          host_o_r  <= ~pend_r;
          host_oe_r <= pend_r;
        end
        HS_START: begin
          host_o_r  <= (cnt_r == 4'h1);
          host_oe_r <= 1'b1;
        end
        HS_FRAMES: begin
          host_o_r  <= ~((ph_r == PH_TURN) && (frame_r == FRAME_LAST));
          host_oe_r <= (ph_r == PH_TURN) && (frame_r == FRAME_LAST);
        end
        HS_STOP: begin
          host_o_r  <= (cnt_r == 4'h1);
          host_oe_r <= 1'b1;
        end
        default: begin
          host_o_r  <= 1'b1;
          host_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // next mode and end-of-cycle pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= SIRQ_CONT;
      done_r <= 1'b0;
    end else begin
      done_r <= rise && (state_r == HS_STOPHI);
      if (rise && (state_r == HS_STOPHI)) begin
        mode_r <= stop_q_r ? SIRQ_QUIET : SIRQ_CONT;
      end
    end
  end

  // a sample period is read mid next period, after the round trip
  assign smp_idx = smp_n_r - 5'h01;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smp_prev_r <= 1'b0;
      smp_n_r    <= 5'h01;
      lvl_r      <= '0;
    end else begin
      if (rise) begin
        smp_prev_r <= (state_r == HS_FRAMES) && (ph_r == PH_SAMPLE);
        smp_n_r    <= frame_r;
      end
      if (fall && smp_prev_r) begin
        lvl_r[smp_idx] <= ~line_q;
      end
    end
  end

  assign link.pci_clk = pclk_r;
  assign link.host_o  = host_o_r;
  assign link.host_oe = host_oe_r;
  assign frame_lvl_o  = lvl_r;
  assign cycle_done_o = done_r;
  assign quiet_mode_o = (mode_r == SIRQ_QUIET);
  assign busy_o       = (state_r != HS_IDLE);
endmodule
`default_nettype wire

// [sim/sirq_link_checker.sv]
`default_nettype none
module sirq_link_checker (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pci_clk,
  input  wire logic dev_o,
  input  wire logic dev_oe,
  input  wire logic host_o,
  input  wire logic host_oe,
  input  wire logic line
);
  logic       host_low;
  logic       dev_low;
  logic       dev_high;
  logic [6:0] host_low_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // decoded drive states of the two ends
  assign host_low = host_oe & ~host_o;
  assign dev_low  = dev_oe & ~dev_o;
  assign dev_high = dev_oe & dev_o;

  // run length of host low drive, cleared whenever it lets go
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_low_r <= 7'h00;
    end else if (host_low) begin
      host_low_r <= host_low_r + 7'h01;
    end else begin
      host_low_r <= 7'h00;
    end
  end

  link_clk_a: assert property ($rose(pci_clk) |->
    pci_clk[*4] ##1 (!pci_clk)[*4] ##1 pci_clk)
    else $error("link clock period wrong");
  one_driver_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the line");
  dev_low_one_a: assert property ($rose(dev_low) |-> dev_low[*8] ##1 !dev_low)
    else $error("device low drive not one link clock");
  dev_high_rec_a: assert property ($rose(dev_high) |-> $past(dev_low))
    else $error("device drove high without a low sample");
  dev_high_one_a: assert property ($rose(dev_high) |-> dev_high[*8] ##1 !dev_oe)
    else $error("device recovery drive not one link clock");
  dev_turn_a: assert property ($fell(dev_oe) |-> (!dev_oe)[*8])
    else $error("device drove in turn-around clock");
  host_high_a: assert property ($rose(host_oe && host_o) |->
    (host_oe && host_o)[*8] ##1 !host_oe)
    else $error("host high drive not one link clock");
  host_width_a: assert property ($fell(host_low) |->
    (host_low_r >= 7'h10 && host_low_r <= 7'h40 && host_low_r[1:0] == 2'h0))
    else $error("host low width out of range");
  // device only takes the line when it was released high a cycle before
  dev_idle_line_a: assert property ($rose(dev_oe) |-> $past(line))
    else $error("device drove onto a busy line");
  // turn-around: the host must have let go before the device drives
  bus_turn_a: assert property (dev_oe |-> !$past(host_oe))
    else $error("device drove right after the host");
endmodule
`default_nettype wire

// [sim/serial_irq_slave_tb.sv]
`default_nettype none
module serial_irq_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sirq_pkg::*;
  logic                 clk_i;
  logic                 rstn_i;
  logic [3:0]           src_req;
  logic [15:0]          src_chan;
  logic                 cyc_req;
  logic [3:0]           start_len;
  logic                 stop_quiet;
  logic                 disc;
  logic [FRAME_CNT-1:0] lvl;
  logic                 done;
  logic                 h_quiet;
  logic                 h_busy;
  logic                 d_quiet;
  logic                 b_err;
  logic                 qwait;
  logic                 d_busy;
  logic                 d_err;
  logic                 b_quiet;
  logic                 b_busy;
  int                   derr_cnt;
  int                   fail_count;
  int                   compares;
  int                   cyc;
  int                   drv_cnt;
  int                   err_cnt;

  sirq_link_if lk ();
  sirq_link_if lk2 ();

  sirq_dev u_sirq_dev (.clk_i(clk_i), .rstn_i(rstn_i), .link(lk.dev), .src_req_i(src_req),
    .src_chan_i(src_chan), .quiet_mode_wait_enable_i(qwait), .start_error_discard_i(1'b0),
    .quiet_mode_o(d_quiet), .busy_o(d_busy), .start_error_o(d_err));
  sirq_host u_sirq_host (.clk_i(clk_i), .rstn_i(rstn_i), .link(lk.host), .cycle_req_i(cyc_req),
    .start_len_i(start_len), .stop_quiet_i(stop_quiet), .frame_lvl_o(lvl),
    .cycle_done_o(done), .quiet_mode_o(h_quiet), .busy_o(h_busy));
  // second device faces a bench host that breaks the start width on purpose
  sirq_dev u_sirq_dev_b (.clk_i(clk_i), .rstn_i(rstn_i), .link(lk2.dev), .src_req_i(4'h1),
    .src_chan_i(16'h0003), .quiet_mode_wait_enable_i(1'b0), .start_error_discard_i(disc),
    .quiet_mode_o(b_quiet), .busy_o(b_busy), .start_error_o(b_err));
  sirq_link_checker u_sirq_link_checker (.clk_i(clk_i), .rstn_i(rstn_i),
    .pci_clk(lk.pci_clk), .dev_o(lk.dev_o), .dev_oe(lk.dev_oe), .host_o(lk.host_o),
    .host_oe(lk.host_oe), .line(lk.line));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // cycle ceiling, event counters for the faulty link, and start errors of the first device
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (lk2.dev_oe === 1'b1) drv_cnt <= drv_cnt + 1;
    if (b_err === 1'b1) err_cnt <= err_cnt + 1;
    if (d_err === 1'b1) derr_cnt <= derr_cnt + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // bounded wait for the host's end-of-cycle pulse, then let mode settle
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("cycle done", done, 1'b1);
    repeat (16) @(posedge clk_i);
    #1;
  endtask

  // one bench link clock: 0 low, 1 high, 2 released
  task automatic lp(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      lk2.pci_clk <= 1'b1;
      lk2.host_oe <= (m != 2'h2);
      lk2.host_o  <= (m != 2'h0);
      repeat (4) @(posedge clk_i);
      lk2.pci_clk <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic t_cont();
    @(posedge clk_i);
    src_req    <= 4'hF;
    src_chan   <= 16'hB063;
    start_len  <= 4'h8;
    stop_quiet <= 1'b1;
    qwait      <= 1'b1;  // next quiet start must hold off
    cyc_req    <= 1'b1;
    @(posedge clk_i);
    cyc_req <= 1'b0;
    wait_done();
    chk("frame levels", 32'(lvl), 32'h00000808);
    chk("host mode", h_quiet, 1'b1);
    chk("device mode", d_quiet, 1'b1);
  endtask

  // no host request: the device itself must open the cycle
  task automatic t_quiet();
    @(posedge clk_i);
    src_chan   <= 16'hB053;
    start_len  <= 4'h4;
    stop_quiet <= 1'b0;
    // change is seen at once, but the armed wait spans 16 link clocks
    repeat (100) @(posedge clk_i);
    #1;
    chk("wait before quiet start", d_busy, 1'b0);
    wait_done();
    chk("frame levels", 32'(lvl), 32'h00000828);
    chk("host mode", h_quiet, 1'b0);
    chk("device mode", d_quiet, 1'b0);
  endtask

  task automatic t_nostart();
    @(posedge clk_i);
    src_req <= 4'h0;
    repeat (300) @(posedge clk_i);
    #1;
    chk("host busy", h_busy, 1'b0);
    chk("device busy", d_busy, 1'b0);
    chk("device start errors", 32'(derr_cnt), 32'h0);
    chk("line idle", lk.line, 1'b1);
  endtask

  // two-clock start is an error, flagged either way; muted unless discard is set
  task automatic t_err(input logic dis, input int exp_drv, input int stop_n, input logic exp_q);
    int d0;
    int e0;
    @(posedge clk_i);
    disc <= dis;
    d0 = drv_cnt;
    e0 = err_cnt;
    lp(2'h0, 2);
    lp(2'h1, 1);
    lp(2'h2, 64);
    lp(2'h0, stop_n);
    lp(2'h1, 1);
    lp(2'h2, 2);
    #1;
    chk("start error", 32'(err_cnt - e0), 32'h1);
    chk("device drive", 32'(drv_cnt - d0), 32'(exp_drv));
    chk("device b mode", b_quiet, exp_q);
    chk("device b busy", b_busy, 1'b0);
  endtask

  initial begin
    rstn_i = 1'b0;
    src_req = 4'h0;
    src_chan = 16'h0000;
    cyc_req = 1'b0;
    start_len = 4'h4;
    stop_quiet = 1'b0;
    disc = 1'b0;
    qwait = 1'b0;
    derr_cnt = 0;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    drv_cnt = 0;
    err_cnt = 0;
    lk2.pci_clk = 1'b0;
    lk2.host_oe = 1'b0;
    lk2.host_o = 1'b1;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("device mode", d_quiet, 1'b0);
    chk("host mode", h_quiet, 1'b0);
    t_cont();
    t_quiet();
    t_nostart();
    t_err(1'b0, 0, 3, 1'b0);
    t_err(1'b1, 16, 2, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
